// [hw/uctl_pkg.sv]
// Purpose: constants and types for the uart control logic block
// Assumes: 32-bit axi4-lite register bus, byte addresses = 4 * index
// Notes:   printed offsets are not word aligned, so they are indices
package uctl_pkg;
   // ****************************************************************
   // register indices and address width
   // ****************************************************************
   localparam logic [15:0] IDX_CONTROL   = 16'h5007;
   localparam logic [15:0] IDX_STATUS    = 16'h500b;
   localparam logic [15:0] IDX_TXBUF     = 16'h5013;
   localparam logic [15:0] IDX_RXBUF     = 16'h5017;
   localparam logic [15:0] IDX_IRQSTAT   = 16'h5020;
   localparam logic [15:0] IDX_IRQMASK   = 16'h5021;
   localparam int          ADDR_W        = 18;
   localparam logic [7:0]  CONTROL_RST   = 8'h00;
   localparam logic [7:0]  CONTROL_WMASK = 8'hdf;
   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int CTL_RXSTAT_IE = 2;
   localparam int CTL_BREAK     = 6;
   localparam int CTL_LOOP      = 7;
   localparam int ST_OVERRUN    = 0;
   localparam int ST_PARITY     = 1;
   localparam int ST_FRAME      = 2;
   localparam int ST_BREAK      = 3;
   localparam int ST_RXREADY    = 5;
   localparam int ST_TXEMPTY    = 7;
   localparam int IRQ_RX        = 0;
   localparam int IRQ_TX        = 1;
   localparam int IRQ_RXSTAT    = 2;
   localparam int IRQ_W         = 3;
   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_HZ        = 50_000_000;
   localparam int BAUD_HZ       = 115_200;
   localparam int BIT_CYCLES    = CLK_HZ / BAUD_HZ;
   localparam int FRAME_BITS    = 10;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {UCTL_IDLE, UCTL_START, UCTL_DATA, UCTL_STOP} uctl_ser_t;
endpackage

// [hw/uctl_tx.sv]
// Purpose: serial transmitter, 8n1, fixed bit time
// Assumes: load only when idle
// Notes:   emits frame on serOut, busy while shifting
`timescale 1ns/10ps
module uctl_tx #(
   parameter int BIT_CYC = uctl_pkg::BIT_CYCLES
) (
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   input  wire logic       load,
   input  wire logic [7:0] data,
   output logic            busy,
   output logic            serOut
);
   uctl_pkg::uctl_ser_t state_r;
   logic [15:0] cnt_r;
   logic [2:0]  bitIdx_r;
   logic [7:0]  shift_r;
   wire tick = (cnt_r == 16'(BIT_CYC - 1));
   assign busy = (state_r != uctl_pkg::UCTL_IDLE);
   // frame sequencer
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r  <= uctl_pkg::UCTL_IDLE;
         cnt_r    <= 16'h0000;
         bitIdx_r <= 3'h0;
         shift_r  <= 8'h00;
         serOut   <= 1'b1;
      end else begin
         cnt_r <= (tick || state_r == uctl_pkg::UCTL_IDLE) ? 16'h0000 : cnt_r + 16'h0001;
         unique case (state_r)
            uctl_pkg::UCTL_IDLE: begin
               serOut <= 1'b1;
               if (load) begin
                  shift_r <= data;
                  state_r <= uctl_pkg::UCTL_START;
                  serOut  <= 1'b0;
               end
            end
            uctl_pkg::UCTL_START: if (tick) begin
               state_r  <= uctl_pkg::UCTL_DATA;
               bitIdx_r <= 3'h0;
               serOut   <= shift_r[0];
            end
            uctl_pkg::UCTL_DATA: if (tick) begin
               shift_r  <= {1'b0, shift_r[7:1]};
               bitIdx_r <= bitIdx_r + 3'h1;
               if (bitIdx_r == 3'h7) begin
                  state_r <= uctl_pkg::UCTL_STOP;
                  serOut  <= 1'b1;
               end else begin
                  serOut <= shift_r[1];
               end
            end
            uctl_pkg::UCTL_STOP: if (tick) begin
               state_r <= uctl_pkg::UCTL_IDLE;
            end
         endcase
      end
   end
endmodule

// [hw/uctl_rx.sv]
// Purpose: serial receiver, 8n1, mid-bit sampling
// Assumes: serIn synchronous to sys_clk
// Notes:   flags frame error on bad stop bit, break on bad stop bit with all-zero data
`timescale 1ns/10ps
module uctl_rx #(
   parameter int BIT_CYC = uctl_pkg::BIT_CYCLES
) (
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   input  wire logic       serIn,
   output logic            done,
   output logic [7:0]      data,
   output logic            frameErr,
   output logic            breakDet
);
   uctl_pkg::uctl_ser_t state_r;
   logic [15:0] cnt_r;
   logic [2:0]  bitIdx_r;
   logic [7:0]  shift_r;
   wire tick = (cnt_r == 16'(BIT_CYC - 1));
   // frame sampler, counter starts half a bit into the start bit
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r  <= uctl_pkg::UCTL_IDLE;
         cnt_r    <= 16'h0000;
         bitIdx_r <= 3'h0;
         shift_r  <= 8'h00;
         done     <= 1'b0;
         data     <= 8'h00;
         frameErr <= 1'b0;
         breakDet <= 1'b0;
      end else begin
         done     <= 1'b0;
         frameErr <= 1'b0;
         breakDet <= 1'b0;
         cnt_r    <= tick ? 16'h0000 : cnt_r + 16'h0001;
         unique case (state_r)
            uctl_pkg::UCTL_IDLE: begin
               cnt_r <= 16'(BIT_CYC / 2);
               if (!serIn) state_r <= uctl_pkg::UCTL_START;
            end
            uctl_pkg::UCTL_START: if (tick) begin
               state_r  <= serIn ? uctl_pkg::UCTL_IDLE : uctl_pkg::UCTL_DATA;
               bitIdx_r <= 3'h0;
            end
            uctl_pkg::UCTL_DATA: if (tick) begin
               shift_r  <= {serIn, shift_r[7:1]};
               bitIdx_r <= bitIdx_r + 3'h1;
               if (bitIdx_r == 3'h7) state_r <= uctl_pkg::UCTL_STOP;
            end
            uctl_pkg::UCTL_STOP: if (tick) begin
               state_r  <= uctl_pkg::UCTL_IDLE;
               done     <= 1'b1;
               data     <= shift_r;
               frameErr <= !serIn;
               breakDet <= !serIn && (shift_r == 8'h00);
            end
         endcase
      end
   end
endmodule

// [hw/uctl_top.sv]
// Purpose: uart control register logic with axi4-lite slave
// Assumes: single clock, one write and one read outstanding
// Notes:   parity error status bit tied low, reserved for a parity-capable receiver
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
module uctl_top #(
   parameter int BIT_CYC = uctl_pkg::BIT_CYCLES
) (
   input  wire logic                        sys_clk,
   input  wire logic                        rst_b,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [uctl_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   output logic [1:0]                       s_axi_bresp,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   input  wire logic [uctl_pkg::ADDR_W-1:0] s_axi_araddr,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   input  wire logic                        rxPin,
   output logic                             txPin,
   output logic                             irq
);
   // ****************************************************************
   // state
   // ****************************************************************
   logic [7:0]  control_r;
   logic [7:0]  rxBuf_r;
   logic        rxReady_r, overrun_r, frameErr_r, break_r;
   logic [2:0]  irqStat_r, irqMask_r;
   logic        awHeld_r, wHeld_r;
   logic [uctl_pkg::ADDR_W-1:0] awAddr_r;
   logic [31:0] wData_r;
   logic        wStrb0_r;
   logic        txLoad, txBusy, txSer, rxDone, rxFrame, rxBreak;
   logic [7:0]  rxData, txData_r;
   logic        txPend_r;
   logic        loopLine_r;
   wire         loopMode  = control_r[uctl_pkg::CTL_LOOP];
   wire         breakMode = control_r[uctl_pkg::CTL_BREAK];
   wire [15:0]  wIdx = 16'(awAddr_r >> 2);
   wire [15:0]  rIdx = 16'(s_axi_araddr >> 2);
   wire         doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
   wire         doRead  = s_axi_arvalid && s_axi_arready;
   wire         wrCtl = doWrite && wStrb0_r && wIdx == uctl_pkg::IDX_CONTROL;
   wire         wrTx  = doWrite && wStrb0_r && wIdx == uctl_pkg::IDX_TXBUF;
   wire         wrIc  = doWrite && wStrb0_r && wIdx == uctl_pkg::IDX_IRQSTAT;
   wire         wrIm  = doWrite && wStrb0_r && wIdx == uctl_pkg::IDX_IRQMASK;
   wire         rdSt  = doRead && rIdx == uctl_pkg::IDX_STATUS;
   wire         rdRx  = doRead && rIdx == uctl_pkg::IDX_RXBUF;
   wire         txEmpty = !txPend_r && !txBusy;
   wire         rxExc = rxDone && (rxFrame || rxBreak || rxReady_r);
   wire [7:0]   status = {txEmpty, 1'b1, rxReady_r, 1'b0, break_r, frameErr_r, 1'b0, overrun_r};
   // ****************************************************************
   // serial engines
   // ****************************************************************
   assign txLoad = txPend_r && !txBusy;
   uctl_tx #(.BIT_CYC(BIT_CYC)) uTx (
      .sys_clk(sys_clk), .rst_b(rst_b), .load(txLoad), .data(txData_r),
      .busy(txBusy), .serOut(txSer));
   // loop-back feeds the transmitter straight into the receiver
   uctl_rx #(.BIT_CYC(BIT_CYC)) uRx (
      .sys_clk(sys_clk), .rst_b(rst_b), .serIn(loopLine_r), .done(rxDone),
      .data(rxData), .frameErr(rxFrame), .breakDet(rxBreak));
   // receive line select, registered
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) loopLine_r <= 1'b1;
      else        loopLine_r <= loopMode ? txSer : rxPin;
   end
   // pin drive: break low, loop-back idle high
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b)         txPin <= 1'b1;
      else if (loopMode)  txPin <= 1'b1;
      else if (breakMode) txPin <= 1'b0;
      else                txPin <= txSer;
   end
   // ****************************************************************
   // control and transmit buffer
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) control_r <= uctl_pkg::CONTROL_RST;
      else if (wrCtl) control_r <= wData_r[7:0] & uctl_pkg::CONTROL_WMASK;
   end
   // holding buffer, drained into the shifter
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         txPend_r <= 1'b0;
         txData_r <= 8'h00;
      end else if (wrTx) begin
         txPend_r <= 1'b1;
         txData_r <= wData_r[7:0];
      end else if (txLoad) begin
         txPend_r <= 1'b0;
      end
   end
   // ****************************************************************
   // receive buffer and line status, ready cleared on buffer read, errors on status read
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rxBuf_r    <= 8'h00;
         rxReady_r  <= 1'b0;
         overrun_r  <= 1'b0;
         frameErr_r <= 1'b0;
         break_r    <= 1'b0;
      end else begin
         if (rxDone) begin
            rxBuf_r   <= rxData;
            rxReady_r <= 1'b1;
         end else if (rdRx) begin
            rxReady_r <= 1'b0;
         end
         // set wins over clear-on-read
         overrun_r  <= (rxDone && rxReady_r) || (overrun_r && !rdSt);
         frameErr_r <= (rxDone && rxFrame) || (frameErr_r && !rdSt);
         break_r    <= (rxDone && rxBreak) || (break_r && !rdSt);
      end
   end
   // ****************************************************************
   // interrupts: sticky status, write-one-to-clear, mask
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         irqStat_r <= 3'h0;
         irqMask_r <= 3'h0;
         irq       <= 1'b0;
      end else begin
         irqStat_r[uctl_pkg::IRQ_RX] <= (rxDone && control_r[1:0] == 2'b01)
            || (irqStat_r[uctl_pkg::IRQ_RX] && !(wrIc && wData_r[uctl_pkg::IRQ_RX]));
         irqStat_r[uctl_pkg::IRQ_TX] <= (txLoad && control_r[4:3] == 2'b01)
            || (irqStat_r[uctl_pkg::IRQ_TX] && !(wrIc && wData_r[uctl_pkg::IRQ_TX]));
         irqStat_r[uctl_pkg::IRQ_RXSTAT] <= (rxExc && control_r[uctl_pkg::CTL_RXSTAT_IE])
            || (irqStat_r[uctl_pkg::IRQ_RXSTAT] && !(wrIc && wData_r[uctl_pkg::IRQ_RXSTAT]));
         if (wrIm) irqMask_r <= wData_r[uctl_pkg::IRQ_W-1:0];
         irq <= |(irqStat_r & irqMask_r);
      end
   end
   // ****************************************************************
   // axi4-lite write channel
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         awHeld_r <= 1'b0;
         wHeld_r  <= 1'b0;
         awAddr_r <= '0;
         wData_r  <= 32'h0000_0000;
         wStrb0_r <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= uctl_pkg::RESP_OKAY;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end else begin
         // ready flags registered from next held and response state
         s_axi_awready <= !doWrite && !(s_axi_awvalid && s_axi_awready) && !awHeld_r
            && !(s_axi_bvalid && !s_axi_bready);
         s_axi_wready  <= !doWrite && !(s_axi_wvalid && s_axi_wready) && !wHeld_r
            && !(s_axi_bvalid && !s_axi_bready);
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r  <= 1'b1;
            wData_r  <= s_axi_wdata;
            wStrb0_r <= s_axi_wstrb[0];
         end
         if (doWrite) begin
            awHeld_r     <= 1'b0;
            wHeld_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wIdx == uctl_pkg::IDX_CONTROL || wIdx == uctl_pkg::IDX_TXBUF
               || wIdx == uctl_pkg::IDX_IRQSTAT || wIdx == uctl_pkg::IDX_IRQMASK)
               ? uctl_pkg::RESP_OKAY : uctl_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // ****************************************************************
   // axi4-lite read channel
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= uctl_pkg::RESP_OKAY;
      end else if (doRead) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= uctl_pkg::RESP_OKAY;
         unique case (rIdx)
            uctl_pkg::IDX_CONTROL: s_axi_rdata <= {24'h0, control_r};
            uctl_pkg::IDX_STATUS:  s_axi_rdata <= {24'h0, status};
            uctl_pkg::IDX_RXBUF:   s_axi_rdata <= {24'h0, rxBuf_r};
            uctl_pkg::IDX_IRQSTAT: s_axi_rdata <= {29'h0, irqStat_r};
            uctl_pkg::IDX_IRQMASK: s_axi_rdata <= {29'h0, irqMask_r};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= uctl_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   // address ready registered, low while a read answer stands
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) s_axi_arready <= 1'b1;
      else        s_axi_arready <= !doRead && !(s_axi_rvalid && !s_axi_rready);
   end
   // ****************************************************************
   // assertions
   // ****************************************************************
   property p_break_low;
      @(posedge sys_clk) disable iff (!rst_b)
      breakMode && !loopMode ##1 breakMode && !loopMode |-> txPin == 1'b0;
   endproperty
   a_break_low: assert property (p_break_low) else $error("break not low");
   property p_break_steady;
      @(posedge sys_clk) disable iff (!rst_b)
      breakMode && !loopMode ##1 breakMode && !loopMode ##1 breakMode && !loopMode
      |-> $stable(txPin);
   endproperty
   a_break_steady: assert property (p_break_steady) else $error("break toggles");
   property p_loop_idle;
      @(posedge sys_clk) disable iff (!rst_b)
      $past(loopMode) |-> txPin == 1'b1;
   endproperty
   a_loop_idle: assert property (p_loop_idle) else $error("loop pin not idle");
   property p_rxstat_off;
      @(posedge sys_clk) disable iff (!rst_b)
      !control_r[uctl_pkg::CTL_RXSTAT_IE] && !irqStat_r[uctl_pkg::IRQ_RXSTAT]
      |=> !irqStat_r[uctl_pkg::IRQ_RXSTAT];
   endproperty
   a_rxstat_off: assert property (p_rxstat_off) else $error("rx status irq while off");
   property p_overrun;
      @(posedge sys_clk) disable iff (!rst_b)
      rxDone && rxReady_r |=> overrun_r;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun missed");
   property p_loop_rx;
      @(posedge sys_clk) disable iff (!rst_b)
      loopMode ##1 loopMode |-> loopLine_r == $past(txSer);
   endproperty
   a_loop_rx: assert property (p_loop_rx) else $error("loop path broken");
   property p_loop_data;
      @(posedge sys_clk) disable iff (!rst_b)
      rxDone |=> rxBuf_r == $past(rxData) && rxReady_r;
   endproperty
   a_loop_data: assert property (p_loop_data) else $error("rx buffer not loaded");
   property p_txempty;
      @(posedge sys_clk) disable iff (!rst_b)
      wrTx |=> !status[uctl_pkg::ST_TXEMPTY];
   endproperty
   a_txempty: assert property (p_txempty) else $error("empty flag wrong");
   property p_reserved;
      @(posedge sys_clk) disable iff (!rst_b)
      wrCtl |=> !control_r[5];
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit stored");
   c_break: cover property (@(posedge sys_clk) disable iff (!rst_b) breakMode ##1 !breakMode);
   c_loop:  cover property (@(posedge sys_clk) disable iff (!rst_b) loopMode && rxDone);
   c_irq:   cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(irq));
endmodule

// [dv/uctl_serial_peer.sv]
// Purpose: remote serial peer facing the uart pins
// Assumes: 8n1 frames, BIT cycles per bit, line idle high
// Notes:   decodes txPin all the time, sends frames on rxPin
`timescale 1ns/10ps
module uctl_serial_peer #(
   parameter int BIT = 8
) (
   input  wire logic sys_clk,
   input  wire logic txPin,
   output logic      rxPin
);
   logic [7:0] lastRx;
   int         rxCount;
   // ****************************************************************
   // frame send and receive
   // ****************************************************************
   initial begin
      rxPin   = 1'b1;
      lastRx  = 8'h00;
      rxCount = 0;
   end
   // one frame plus one idle bit, stop level chosen by caller for frame error
   task automatic send(input logic [7:0] d, input logic stopBit);
      logic [10:0] bits;
      bits = {1'b1, stopBit, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxPin <= bits[i];
         repeat (BIT) @(posedge sys_clk);
      end
   endtask
   // mid-bit sampling of frames sent by the device
   always begin
      @(negedge txPin);
      repeat (BIT / 2) @(posedge sys_clk);
      if (txPin === 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge sys_clk);
            lastRx[i] = txPin;
         end
         repeat (BIT) @(posedge sys_clk);
         rxCount++;
      end
   end
endmodule

// [dv/testbench.sv]
// Purpose: self-checking bench for the uart control block
// Assumes: BIT_CYC shortened to 8, register bus is axi4-lite
// Notes:   bready and rready held high, answers never stall
`timescale 1ns/10ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench;
   localparam int          BIT    = 8;
   localparam logic [17:0] A_CTL  = {uctl_pkg::IDX_CONTROL, 2'b00};
   localparam logic [17:0] A_STAT = {uctl_pkg::IDX_STATUS, 2'b00};
   localparam logic [17:0] A_TX   = {uctl_pkg::IDX_TXBUF, 2'b00};
   localparam logic [17:0] A_RX   = {uctl_pkg::IDX_RXBUF, 2'b00};
   localparam logic [17:0] A_IST  = {uctl_pkg::IDX_IRQSTAT, 2'b00};
   localparam logic [17:0] A_IMK  = {uctl_pkg::IDX_IRQMASK, 2'b00};
   logic        sys_clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, rxPin, txPin, irq;
   logic [17:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   int          fail_count, num_checks, cyc, highs, lows, cnt;
   // ****************************************************************
   // design, peer and clock
   // ****************************************************************
   uctl_top #(.BIT_CYC(BIT)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .rxPin(rxPin), .txPin(txPin), .irq(irq));
   uctl_serial_peer #(.BIT(BIT)) peer (.sys_clk(sys_clk), .txPin(txPin), .rxPin(rxPin));
   always #10 sys_clk = ~sys_clk;
   // hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         print_verdict();
      end
   end
   // ****************************************************************
   // bus tasks
   // ****************************************************************
   // write with address and data offered together
   task automatic wrReg(input logic [17:0] a, input logic [31:0] d);
      logic awHit, wHit, bHit;
      bHit = 1'b0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      while (!bHit) begin
         @(negedge sys_clk);
         awHit = s_axi_awvalid & s_axi_awready;
         wHit  = s_axi_wvalid & s_axi_wready;
         bHit  = s_axi_bvalid;
         rsp   = s_axi_bresp;
         @(posedge sys_clk);
         if (awHit) s_axi_awvalid <= 1'b0;
         if (wHit) s_axi_wvalid <= 1'b0;
      end
   endtask
   task automatic rdReg(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
      logic arHit, rHit;
      rHit = 1'b0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      while (!rHit) begin
         @(negedge sys_clk);
         arHit = s_axi_arvalid & s_axi_arready;
         rHit  = s_axi_rvalid;
         d     = s_axi_rdata;
         r     = s_axi_rresp;
         @(posedge sys_clk);
         if (arHit) s_axi_arvalid <= 1'b0;
      end
   endtask
   // read and compare under a mask
   task automatic rdChk(input logic [17:0] a, input logic [31:0] e, input logic [31:0] m);
      rdReg(a, rd, rsp);
      `CHK(rd & m, e)
      `CHK(rsp, uctl_pkg::RESP_OKAY)
   endtask
   // count transmit line levels over n cycles
   task automatic watchTx(input int n);
      highs = 0;
      lows  = 0;
      repeat (n) begin
         @(negedge sys_clk);
         if (txPin === 1'b1) highs++;
         else lows++;
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      {sys_clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3f;
      {fail_count, num_checks, cyc} = '0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      rdChk(A_CTL, 32'h00, 32'hdf);
      rdChk(A_STAT, 32'hc0, 32'hff);
      rdReg({16'h500c, 2'b00}, rd, rsp);
      `CHK({rsp, rd}, {uctl_pkg::RESP_SLVERR, 32'h0})
      wrReg(A_STAT, 32'h0);
      `CHK(rsp, uctl_pkg::RESP_SLVERR)
      $display("test reset done");
      wrReg(A_IMK, 32'h07);
      `CHK(rsp, uctl_pkg::RESP_OKAY)
      wrReg(A_CTL, 32'h01);
      peer.send(8'ha5, 1'b1);
      repeat (4) @(posedge sys_clk);
      rdChk(A_STAT, 32'he0, 32'hff);
      rdChk(A_RX, 32'ha5, 32'hff);
      rdChk(A_IST, 32'h01, 32'h07);
      `CHK(irq, 1'b1)
      wrReg(A_IST, 32'h01);
      repeat (3) @(posedge sys_clk);
      `CHK(irq, 1'b0)
      $display("test rx done");
      wrReg(A_CTL, 32'h04);
      peer.send(8'h11, 1'b1);
      peer.send(8'h22, 1'b1);
      repeat (4) @(posedge sys_clk);
      rdChk(A_STAT, 32'he1, 32'hff);
      rdChk(A_IST, 32'h04, 32'h07);
      rdChk(A_STAT, 32'he0, 32'hff);
      rdReg(A_RX, rd, rsp);
      wrReg(A_IST, 32'h07);
      wrReg(A_CTL, 32'h00);
      peer.send(8'h33, 1'b0);
      repeat (2 * BIT) @(posedge sys_clk);
      rdChk(A_STAT, 32'h04, 32'h04);
      rdChk(A_IST, 32'h00, 32'h07);
      rdReg(A_RX, rd, rsp);
      $display("test rx status done");
      wrReg(A_CTL, 32'h08);
      wrReg(A_TX, 32'h3c);
      rdChk(A_STAT, 32'h00, 32'h80);
      repeat (12 * BIT) @(posedge sys_clk);
      `CHK(peer.lastRx, 8'h3c)
      rdChk(A_STAT, 32'h80, 32'h80);
      rdChk(A_IST, 32'h02, 32'h07);
      wrReg(A_IST, 32'h07);
      $display("test tx done");
      wrReg(A_CTL, 32'h40);
      wrReg(A_TX, 32'h00);
      watchTx(11 * BIT);
      `CHK(highs, 0)
      rdChk(A_STAT, 32'h80, 32'h80);
      wrReg(A_CTL, 32'h00);
      repeat (2) @(posedge sys_clk);
      `CHK(txPin, 1'b1)
      $display("test break done");
      wrReg(A_CTL, 32'h80);
      rdChk(A_CTL, 32'h80, 32'hdf);
      cnt = peer.rxCount;
      wrReg(A_TX, 32'h5a);
      watchTx(12 * BIT);
      `CHK(lows, 0)
      rdChk(A_RX, 32'h5a, 32'hff);
      `CHK(peer.rxCount, cnt)
      $display("test loopback done");
      print_verdict();
   end
endmodule
